// >>> hw/timer8_defines.svh
// Register indices, field positions, reset values and limits of the timer pair.
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH

`define T8_ADDR_W 8
`define T8_DATA_W 32
`define T8_IDX_W 6

// Register indices; the byte address on the bus is four times the index.
`define T8_IDX_CTRL_A_T0 6'h30
`define T8_IDX_CTRL_A_T1 6'h2F
`define T8_IDX_CTRL_B_T0 6'h33
`define T8_IDX_CTRL_B_T1 6'h2E
`define T8_IDX_COUNT_T0 6'h32
`define T8_IDX_COUNT_T1 6'h2D
`define T8_IDX_CMP_A_T0 6'h36
`define T8_IDX_CMP_A_T1 6'h2C
`define T8_IDX_CMP_B_T0 6'h3C
`define T8_IDX_CMP_B_T1 6'h2B
`define T8_IDX_FLAGS_T0 6'h38
`define T8_IDX_FLAGS_T1 6'h2A

// Control register A fields.
`define T8_A_COM_A_HI 7
`define T8_A_COM_A_LO 6
`define T8_A_COM_B_HI 5
`define T8_A_COM_B_LO 4
`define T8_A_WGM_HI 1
`define T8_A_WGM_LO 0
`define T8_A_RW_MASK 8'hF3

// Control register B fields.
`define T8_B_FORCE_A 7
`define T8_B_FORCE_B 6
`define T8_B_WGM_HIGH 3
`define T8_B_CS_HI 2
`define T8_B_CS_LO 0
`define T8_B_RW_MASK 8'h0F

// Flag register fields.
`define T8_F_OVF 0
`define T8_F_CMP_A 1
`define T8_F_CMP_B 2

`define T8_RESET_VAL 8'h00
`define T8_MAX 8'hFF
`define T8_BOTTOM 8'h00

`define T8_PRESC_W 10
`define T8_RESP_OKAY 2'h0
`define T8_RESP_SLVERR 2'h2

`endif

// >>> hw/timer8_pkg.sv
// Types shared by the timer pair.
package timer8_pkg;

	typedef enum logic [3:0] {
		WAVE_NONPWM = 4'h1,
		WAVE_PHASE = 4'h2,
		WAVE_FAST = 4'h4,
		WAVE_RESERVED = 4'h8
	} wave_kind_t;

	typedef enum logic [2:0] {
		CS_STOP = 3'h0,
		CS_DIRECT = 3'h1,
		CS_DIV8 = 3'h2,
		CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4,
		CS_DIV1024 = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} clock_select_t;

endpackage : timer8_pkg

// >>> hw/timer8_mode_clock_control.sv
// Two 8-bit timers: mode, clock select and waveform control, AXI4-Lite.
`timescale 1ns/1ps
`include "timer8_defines.svh"

module timer8_mode_clock_control #(
	parameter int TIMERS = 2
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [`T8_ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [`T8_DATA_W-1:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [`T8_ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [`T8_DATA_W-1:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic [TIMERS-1:0] i_external_count_input,
	input wire logic [TIMERS-1:0] i_compare_a_dir_out,
	input wire logic [TIMERS-1:0] i_compare_b_dir_out,
	output logic [TIMERS-1:0] o_compare_a_wave_out,
	output logic [TIMERS-1:0] o_compare_b_wave_out,
	output logic [TIMERS-1:0] o_compare_a_pin_drive,
	output logic [TIMERS-1:0] o_compare_b_pin_drive,
	output logic [TIMERS-1:0] o_overflow_flag
);
	import timer8_pkg::*;

	localparam logic [5:0] IDX_CTRL_A [2] = '{`T8_IDX_CTRL_A_T0,
		`T8_IDX_CTRL_A_T1};
	localparam logic [5:0] IDX_CTRL_B [2] = '{`T8_IDX_CTRL_B_T0,
		`T8_IDX_CTRL_B_T1};
	localparam logic [5:0] IDX_COUNT [2] = '{`T8_IDX_COUNT_T0,
		`T8_IDX_COUNT_T1};
	localparam logic [5:0] IDX_CMP_A [2] = '{`T8_IDX_CMP_A_T0,
		`T8_IDX_CMP_A_T1};
	localparam logic [5:0] IDX_CMP_B [2] = '{`T8_IDX_CMP_B_T0,
		`T8_IDX_CMP_B_T1};
	localparam logic [5:0] IDX_FLAGS [2] = '{`T8_IDX_FLAGS_T0,
		`T8_IDX_FLAGS_T1};

	// The index tables above hold exactly two timers.
	if (TIMERS != 2) begin : g_bad_timers
		$error("timer8_mode_clock_control serves exactly two timers");
	end

	function automatic wave_kind_t kind_of(input logic [2:0] mode);
		case (mode)
			3'h0, 3'h2: kind_of = WAVE_NONPWM;
			3'h1, 3'h5: kind_of = WAVE_PHASE;
			3'h3, 3'h7: kind_of = WAVE_FAST;
			default: kind_of = WAVE_RESERVED;
		endcase
	endfunction : kind_of

	// Next level of one waveform output for a counter tick or a forced match.
	function automatic logic next_wave(input wave_kind_t kind,
		input logic [1:0] com, input logic cur, input logic match,
		input logic top_tick, input logic down, input logic cmp_is_top,
		input logic toggle_ok);
		next_wave = cur;
		case (kind)
			WAVE_NONPWM: begin
				if (match) begin
					case (com)
						2'b01: next_wave = ~cur;
						2'b10: next_wave = 1'b0;
						2'b11: next_wave = 1'b1;
						default: next_wave = cur;
					endcase
				end
			end
			WAVE_FAST: begin
				if (com[1]) begin
					if (match && !cmp_is_top) begin
						next_wave = com[0];
					end
					if (top_tick) begin
						next_wave = ~com[0];
					end
				end else if (com[0] && toggle_ok && match) begin
					next_wave = ~cur;
				end
			end
			WAVE_PHASE: begin
				if (com[1]) begin
					if (match && !cmp_is_top) begin
						next_wave = down ? ~com[0] : com[0];
					end
					if (top_tick && cmp_is_top) begin
						next_wave = ~com[0];
					end
				end else if (com[0] && toggle_ok && match) begin
					next_wave = ~cur;
				end
			end
			default: next_wave = cur;
		endcase
	endfunction : next_wave

	function automatic logic hit(input logic [`T8_ADDR_W-1:0] addr,
		input logic [5:0] idx);
		hit = (addr[`T8_ADDR_W-1:2] == idx);
	endfunction : hit

	// Bus side: write channel.
	logic aw_held_reg;
	logic w_held_reg;
	logic [`T8_ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wlane_reg;
	logic wr_en;
	logic wr_known;

	assign wr_en = aw_held_reg && w_held_reg && !o_bvalid;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wlane_reg <= 1'b0;
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_bvalid <= 1'b0;
			o_bresp <= `T8_RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= i_wdata[7:0];
				wlane_reg <= i_wstrb[0];
				o_wready <= 1'b0;
			end
			if (wr_en) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= wr_known ? `T8_RESP_OKAY : `T8_RESP_SLVERR;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	// Views of each timer's registers for the read path.
	logic [7:0] view_ctrl_a [2];
	logic [7:0] view_ctrl_b [2];
	logic [7:0] view_count [2];
	logic [7:0] view_cmp_a [2];
	logic [7:0] view_cmp_b [2];
	logic [7:0] view_flags [2];
	logic [7:0] rd_val;
	logic rd_known;

	always_comb begin
		rd_val = 8'h00;
		rd_known = 1'b0;
		wr_known = 1'b0;
		for (int t = 0; t < 2; t++) begin
			if (hit(i_araddr, IDX_CTRL_A[t])) begin
				rd_val = view_ctrl_a[t];
				rd_known = 1'b1;
			end
			if (hit(i_araddr, IDX_CTRL_B[t])) begin
				rd_val = view_ctrl_b[t];
				rd_known = 1'b1;
			end
			if (hit(i_araddr, IDX_COUNT[t])) begin
				rd_val = view_count[t];
				rd_known = 1'b1;
			end
			if (hit(i_araddr, IDX_CMP_A[t])) begin
				rd_val = view_cmp_a[t];
				rd_known = 1'b1;
			end
			if (hit(i_araddr, IDX_CMP_B[t])) begin
				rd_val = view_cmp_b[t];
				rd_known = 1'b1;
			end
			if (hit(i_araddr, IDX_FLAGS[t])) begin
				rd_val = view_flags[t];
				rd_known = 1'b1;
			end
			if (hit(awaddr_reg, IDX_CTRL_A[t]) || hit(awaddr_reg, IDX_CTRL_B[t]) ||
				hit(awaddr_reg, IDX_COUNT[t]) || hit(awaddr_reg, IDX_CMP_A[t]) ||
				hit(awaddr_reg, IDX_CMP_B[t]) || hit(awaddr_reg, IDX_FLAGS[t])) begin
				wr_known = 1'b1;
			end
		end
	end

	// Bus side: read channel, answered one cycle after the address.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= `T8_RESP_OKAY;
		end else begin
			if (i_arvalid && o_arready) begin
				o_arready <= 1'b0;
				o_rvalid <= 1'b1;
				o_rdata <= {24'h000000, rd_val};
				o_rresp <= rd_known ? `T8_RESP_OKAY : `T8_RESP_SLVERR;
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
				o_arready <= 1'b1;
			end
		end
	end

	// The prescaler runs freely and is shared by both timers, so the first
	// prescaled count after enabling lands anywhere within one period.
	logic [`T8_PRESC_W-1:0] presc_reg;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			presc_reg <= '0;
		end else begin
			presc_reg <= presc_reg + 1'b1;
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_timer
		logic [7:0] ctrl_a_reg;
		logic [3:0] ctrl_b_reg;
		logic [7:0] count_reg;
		logic [7:0] cmp_a_buf_reg;
		logic [7:0] cmp_a_reg;
		logic [7:0] cmp_b_buf_reg;
		logic [7:0] cmp_b_reg;
		logic [2:0] flags_reg;
		logic down_reg;
		logic sync1_reg;
		logic sync2_reg;
		logic prev_reg;
		logic [2:0] mode;
		logic [2:0] cs;
		wave_kind_t kind;
		logic tick;
		logic [7:0] top;
		logic at_top;
		logic top_tick;
		logic match_a;
		logic match_b;
		logic ovf_set;
		logic force_a;
		logic force_b;
		logic wr_ctrl_a;
		logic wr_ctrl_b;
		logic wr_count;
		logic wr_flags;

		assign wr_ctrl_a = wr_en && wlane_reg && hit(awaddr_reg, IDX_CTRL_A[g]);
		assign wr_ctrl_b = wr_en && wlane_reg && hit(awaddr_reg, IDX_CTRL_B[g]);
		assign wr_count = wr_en && wlane_reg && hit(awaddr_reg, IDX_COUNT[g]);
		assign wr_flags = wr_en && wlane_reg && hit(awaddr_reg, IDX_FLAGS[g]);

		assign mode = {ctrl_b_reg[`T8_B_WGM_HIGH],
			ctrl_a_reg[`T8_A_WGM_HI:`T8_A_WGM_LO]};
		assign kind = kind_of(mode);
		assign cs = ctrl_b_reg[`T8_B_CS_HI:`T8_B_CS_LO];

		assign view_ctrl_a[g] = ctrl_a_reg & `T8_A_RW_MASK;
		assign view_ctrl_b[g] = {4'h0, ctrl_b_reg};
		assign view_count[g] = count_reg;
		assign view_cmp_a[g] = cmp_a_buf_reg;
		assign view_cmp_b[g] = cmp_b_buf_reg;
		assign view_flags[g] = {5'h00, flags_reg};

		// Force strobes only reach the outputs in non-PWM modes.
		assign force_a = wr_ctrl_b && wdata_reg[`T8_B_FORCE_A] &&
			(kind == WAVE_NONPWM);
		assign force_b = wr_ctrl_b && wdata_reg[`T8_B_FORCE_B] &&
			(kind == WAVE_NONPWM);

		// The pin is sampled regardless of its direction, so software can
		// drive it and count its own edges.
		always_ff @(posedge i_ref_clk) begin
			if (!i_rstn) begin
				sync1_reg <= 1'b0;
				sync2_reg <= 1'b0;
				prev_reg <= 1'b0;
			end else begin
				sync1_reg <= i_external_count_input[g];
				sync2_reg <= sync1_reg;
				prev_reg <= sync2_reg;
			end
		end

		always_comb begin
			case (clock_select_t'(cs))
				CS_STOP: tick = 1'b0;
				CS_DIRECT: tick = 1'b1;
				CS_DIV8: tick = &presc_reg[2:0];
				CS_DIV64: tick = &presc_reg[5:0];
				CS_DIV256: tick = &presc_reg[7:0];
				CS_DIV1024: tick = &presc_reg[9:0];
				CS_EXT_FALL: tick = prev_reg && !sync2_reg;
				CS_EXT_RISE: tick = !prev_reg && sync2_reg;
				default: tick = 1'b0;
			endcase
		end

		// Modes 2, 5 and 7 take TOP from compare A, the rest use MAX.
		assign top = (mode == 3'h2 || mode == 3'h5 || mode == 3'h7) ?
			cmp_a_reg : `T8_MAX;
		assign at_top = (count_reg == top);
		assign top_tick = tick && at_top;
		assign match_a = tick && (count_reg == cmp_a_reg);
		assign match_b = tick && (count_reg == cmp_b_reg);

		always_comb begin
			case (mode)
				3'h1, 3'h5: ovf_set = tick && down_reg &&
					(count_reg == `T8_BOTTOM);
				3'h7: ovf_set = top_tick;
				default: ovf_set = tick && (count_reg == `T8_MAX);
			endcase
		end

		always_ff @(posedge i_ref_clk) begin
			if (!i_rstn) begin
				ctrl_a_reg <= `T8_RESET_VAL;
				ctrl_b_reg <= 4'h0;
			end else begin
				if (wr_ctrl_a) begin
					ctrl_a_reg <= wdata_reg & `T8_A_RW_MASK;
				end
				if (wr_ctrl_b) begin
					ctrl_b_reg <= wdata_reg[3:0];
				end
			end
		end

		// Compare values are double-buffered; PWM modes load them at TOP so
		// a period never sees a half-updated duty cycle.
		always_ff @(posedge i_ref_clk) begin
			if (!i_rstn) begin
				cmp_a_buf_reg <= `T8_RESET_VAL;
				cmp_b_buf_reg <= `T8_RESET_VAL;
				cmp_a_reg <= `T8_RESET_VAL;
				cmp_b_reg <= `T8_RESET_VAL;
			end else begin
				if (wr_en && wlane_reg && hit(awaddr_reg, IDX_CMP_A[g])) begin
					cmp_a_buf_reg <= wdata_reg;
				end
				if (wr_en && wlane_reg && hit(awaddr_reg, IDX_CMP_B[g])) begin
					cmp_b_buf_reg <= wdata_reg;
				end
				if (kind == WAVE_NONPWM || kind == WAVE_RESERVED ||
					top_tick) begin
					cmp_a_reg <= cmp_a_buf_reg;
					cmp_b_reg <= cmp_b_buf_reg;
				end
			end
		end

		always_ff @(posedge i_ref_clk) begin
			if (!i_rstn) begin
				count_reg <= `T8_RESET_VAL;
				down_reg <= 1'b0;
			end else if (wr_count) begin
				count_reg <= wdata_reg;
			end else if (tick) begin
				if (kind == WAVE_PHASE) begin
					if (!down_reg && at_top) begin
						down_reg <= 1'b1;
						count_reg <= count_reg - 8'h01;
					end else if (down_reg && count_reg == `T8_BOTTOM) begin
						down_reg <= 1'b0;
						count_reg <= count_reg + 8'h01;
					end else if (down_reg) begin
						count_reg <= count_reg - 8'h01;
					end else begin
						count_reg <= count_reg + 8'h01;
					end
				end else if (at_top) begin
					// Only the count reaching TOP on a tick clears here, never a force.
					count_reg <= `T8_BOTTOM;
					down_reg <= 1'b0;
				end else begin
					count_reg <= count_reg + 8'h01;
					down_reg <= 1'b0;
				end
			end
		end

		// A hardware set in the same cycle as a write-one clear wins.
		always_ff @(posedge i_ref_clk) begin
			if (!i_rstn) begin
				flags_reg <= 3'h0;
			end else begin
				flags_reg <= (flags_reg & ~(wr_flags ? wdata_reg[2:0] : 3'h0)) |
					{match_b, match_a, ovf_set};
			end
		end

		always_ff @(posedge i_ref_clk) begin
			if (!i_rstn) begin
				o_compare_a_wave_out[g] <= 1'b0;
				o_compare_b_wave_out[g] <= 1'b0;
				o_compare_a_pin_drive[g] <= 1'b0;
				o_compare_b_pin_drive[g] <= 1'b0;
				o_overflow_flag[g] <= 1'b0;
			end else begin
				o_compare_a_wave_out[g] <= next_wave(kind,
					ctrl_a_reg[`T8_A_COM_A_HI:`T8_A_COM_A_LO],
					o_compare_a_wave_out[g], match_a || force_a, top_tick,
					down_reg, cmp_a_reg == top, mode[2]);
				o_compare_b_wave_out[g] <= next_wave(kind,
					ctrl_a_reg[`T8_A_COM_B_HI:`T8_A_COM_B_LO],
					o_compare_b_wave_out[g], match_b || force_b, top_tick,
					down_reg, cmp_b_reg == top, 1'b0);
				o_compare_a_pin_drive[g] <= i_compare_a_dir_out[g] &&
					(ctrl_a_reg[`T8_A_COM_A_HI:`T8_A_COM_A_LO] != 2'b00);
				o_compare_b_pin_drive[g] <= i_compare_b_dir_out[g] &&
					(ctrl_a_reg[`T8_A_COM_B_HI:`T8_A_COM_B_LO] != 2'b00);
				o_overflow_flag[g] <= flags_reg[`T8_F_OVF];
			end
		end
	end

endmodule : timer8_mode_clock_control

// >>> tb/timer8_properties.sv
// Concurrent checks on the bus and pin ports of the timer pair.
`timescale 1ns/1ps
`include "timer8_defines.svh"
module timer8_properties #(
	parameter int TIMERS = 2
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic [1:0] o_bresp,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic [`T8_ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [`T8_DATA_W-1:0] o_rdata,
	input wire logic [1:0] o_rresp,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic [TIMERS-1:0] i_compare_b_dir_out,
	input wire logic [TIMERS-1:0] o_compare_b_pin_drive,
	input wire logic [TIMERS-1:0] o_compare_b_wave_out,
	input wire logic [TIMERS-1:0] o_overflow_flag
);
	logic [5:0] rd_idx_reg;
	logic aw_take, w_take;
	assign aw_take = i_awvalid && o_awready;
	assign w_take = i_wvalid && o_wready;
	// The register index of the read in flight qualifies its data.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn)
			rd_idx_reg <= 6'h00;
		else if (i_arvalid && o_arready)
			rd_idx_reg <= i_araddr[7:2];
	end
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);
	AST_AW_CLOSED: assert property (aw_take |=> !o_awready)
		else $error("write address accepted twice");
	AST_W_CLOSED: assert property (w_take |=> !o_wready)
		else $error("write data accepted twice");
	AST_B_LATENCY: assert property (aw_take && w_take |-> ##2 o_bvalid)
		else $error("write response late");
	AST_B_STANDS: assert property (o_bvalid && !i_bready |=>
		o_bvalid && $stable(o_bresp)) else $error("write response dropped");
	AST_R_LATENCY: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read data late");
	AST_R_STANDS: assert property (o_rvalid && !i_rready |=>
		o_rvalid && $stable(o_rdata)) else $error("read data dropped");
	AST_AR_CLOSED: assert property (o_rvalid |-> !o_arready)
		else $error("read address open during answer");
	AST_ERR_ZERO: assert property (o_rvalid && o_rresp != `T8_RESP_OKAY |->
		o_rdata == 32'h0) else $error("error read returned data");
	AST_CTRL_B_ZERO: assert property (o_rvalid &&
		(rd_idx_reg == `T8_IDX_CTRL_B_T0 || rd_idx_reg == `T8_IDX_CTRL_B_T1)
		|-> o_rdata[31:4] == 28'h0) else $error("control B high bits set");
	AST_CTRL_A_ZERO: assert property (o_rvalid &&
		(rd_idx_reg == `T8_IDX_CTRL_A_T0 || rd_idx_reg == `T8_IDX_CTRL_A_T1)
		|-> o_rdata[3:2] == 2'h0) else $error("control A gap bits set");
	AST_B_DRIVE_DIR: assert property (
		(o_compare_b_pin_drive & ~$past(i_compare_b_dir_out)) == '0)
		else $error("pin driven while direction is input");
	COV_SLVERR: cover property (o_bvalid && o_bresp == `T8_RESP_SLVERR);
	COV_READ: cover property (o_rvalid && i_rready);
	COV_WAVE: cover property ($rose(o_compare_b_wave_out[0]));
	COV_OVF: cover property ($rose(o_overflow_flag[0]));
endmodule : timer8_properties

bind timer8_mode_clock_control timer8_properties #(.TIMERS(TIMERS)) u_props (
	.i_ref_clk, .i_rstn, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
	.o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
	.o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_compare_b_dir_out,
	.o_compare_b_pin_drive, .o_compare_b_wave_out, .o_overflow_flag);

// >>> tb/tb.sv
// Self-checking bench for mode and clock control of the timer pair.
`timescale 1ns/1ps
`include "timer8_defines.svh"
module tb;
	import timer8_pkg::*;
	logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdv, hi, lfsr_reg;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, ext, dira, dirb, wa, wb, pda, pdb, ovf;
	int errors, num_checks;
	localparam logic [5:0] AI[2] = '{`T8_IDX_CTRL_A_T0, `T8_IDX_CTRL_A_T1};
	localparam logic [5:0] BI[2] = '{`T8_IDX_CTRL_B_T0, `T8_IDX_CTRL_B_T1};
	localparam logic [5:0] CI[2] = '{`T8_IDX_COUNT_T0, `T8_IDX_COUNT_T1};
	localparam logic [5:0] FI[2] = '{`T8_IDX_FLAGS_T0, `T8_IDX_FLAGS_T1};
	localparam logic [1:0] COM[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
	localparam logic FE[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	localparam int ES[3] = '{7, 6, 0};
	localparam int EC[3] = '{5, 5, 0};
	localparam int DIV[5] = '{1, 8, 64, 256, 1024};
	localparam int M[9] = '{3, 3, 3, 1, 1, 1, 7, 5, 2};
	localparam int CB[9] = '{64, 64, 255, 64, 64, 255, 144, 64, 64};
	localparam int CM[9] = '{2, 3, 2, 2, 3, 2, 2, 2, 1};
	localparam int LO[9] = '{250, 755, 1020, 245, 750, 1020, 1020, 505,
		505};
	localparam int HI[9] = '{270, 775, 1020, 270, 775, 1020, 1020, 525,
		515};
	timer8_mode_clock_control dut (
		.i_ref_clk(clk), .i_rstn(rstn), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_external_count_input(ext),
		.i_compare_a_dir_out(dira), .i_compare_b_dir_out(dirb),
		.o_compare_a_wave_out(wa), .o_compare_b_wave_out(wb),
		.o_compare_a_pin_drive(pda), .o_compare_b_pin_drive(pdb),
		.o_overflow_flag(ovf));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic aw_d;
		logic w_d;
		@(posedge clk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_d = 1'b0;
		w_d = 1'b0;
		while (!(aw_d && w_d)) begin
			@(posedge clk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				aw_d = 1'b1;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				w_d = 1'b1;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] idx);
		@(posedge clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rdv = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#1000000;
		errors++;
		report_and_stop();
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wstrb, wdata} = '0;
		{ext, dira, dirb} = 6'h0;
		rstn = 1'b0;
		lfsr_reg = 32'h5952;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (int t = 0; t < 2; t++) begin
			rd(AI[t]);
			chk(rdv, 32'h0);
			rd(BI[t]);
			chk(rdv, 32'h0);
		end
		rd(6'h00);
		chk(rs, `T8_RESP_SLVERR);
		chk(rdv, 32'h0);
		wr(6'h01, 8'hFF);
		chk(rs, `T8_RESP_SLVERR);
		// Force bits stay out of random writes since PWM modes may be drawn.
		repeat (8) begin
			lfsr_reg = lfsr_next(lfsr_reg);
			wr(AI[lfsr_reg[0]], lfsr_reg[15:8]);
			rd(AI[lfsr_reg[0]]);
			chk(rdv, lfsr_reg[15:8] & 8'hF3);
			wr(BI[lfsr_reg[0]], lfsr_reg[23:16] & 8'h3F);
			rd(BI[lfsr_reg[0]]);
			chk(rdv, lfsr_reg[23:16] & 8'h0F);
		end
		for (int t = 0; t < 2; t++) begin
			wr(BI[t], 8'h00);
			wr(CI[t], 8'h00);
			wr(FI[t], 8'h07);
			dira[t] <= 1'b1;
			dirb[t] <= 1'b1;
			for (int k = 0; k < 4; k++) begin
				wr(AI[t], {COM[k], COM[k], 4'h0});
				wr(BI[t], 8'hC0);
				repeat (2) @(posedge clk);
				chk(wb[t], FE[k]);
				chk(wa[t], FE[k]);
				chk(pda[t] & pdb[t], 1'b1);
			end
			rd(BI[t]);
			chk(rdv, 32'h0);
			rd(FI[t]);
			chk(rdv, 32'h0);
			rd(CI[t]);
			chk(rdv, 32'h0);
			dirb[t] <= 1'b0;
			repeat (2) @(posedge clk);
			chk(pdb[t], 1'b0);
			wr(AI[t], 8'h33);
			wr(BI[t], 8'h40);
			repeat (2) @(posedge clk);
			chk(wb[t], 1'b0);
			wr(AI[t], 8'h00);
			for (int j = 0; j < 3; j++) begin
				wr(CI[t], 8'h00);
				wr(BI[t], ES[j]);
				repeat (10) begin
					ext[t] <= ~ext[t];
					repeat (4) @(posedge clk);
				end
				rd(CI[t]);
				chk(rdv, EC[j]);
			end
		end
		for (int t = 0; t < 2; t++) begin
			wr(CI[t], 8'h80);
			repeat (20) @(posedge clk);
			rd(CI[t]);
			chk(rdv, 32'h80);
			chk(ovf[t], 1'b0);
			wr(CI[t], 8'hF0);
			wr(BI[t], 8'h01);
			repeat (40) @(posedge clk);
			chk(ovf[t], 1'b1);
			wr(BI[t], 8'h00);
			wr(FI[t], 8'h01);
			rd(FI[t]);
			chk(rdv[0], 1'b0);
		end
		// The shared prescaler runs free, so each tap may gain one count, plus 8 / DIV[j] more for the bus write cycles.
		for (int j = 0; j < 5; j++) begin
			wr(CI[0], 8'h00);
			wr(BI[0], j + 1);
			repeat (20 * DIV[j]) @(posedge clk);
			wr(BI[0], 8'h00);
			rd(CI[0]);
			chk(rdv >= 20 && rdv <= 21 + 8 / DIV[j], 1'b1);
		end
		for (int r = 0; r < 9; r++) begin
			wr(BI[0], 8'h00);
			wr(`T8_IDX_CMP_A_T0, 8'h7F);
			wr(`T8_IDX_CMP_B_T0, CB[r]);
			wr(AI[0], {2'h0, CM[r][1:0], 2'h0, M[r][1:0]});
			wr(BI[0], {4'h0, M[r][2], 3'h1});
			repeat (600) @(posedge clk);
			hi = 32'h0;
			repeat (1020) begin
				@(posedge clk);
				hi = hi + wb[0];
			end
			chk(hi >= LO[r] && hi <= HI[r], 1'b1);
		end
		report_and_stop();
	end
endmodule : tb
